// File: cagen_regs.svh
// Summary of operation
// - relative branch: next instruction address plus sign-extended 8 or 16-bit displacement
// - displacement arithmetic is used by relative branches and based operands only
// - immediate jump loads 20-bit target, or 16-bit target with upper nibble zero
// - table call reads word at 0080H plus twice 5-bit index, into program counter
// - table call targets stay in 00000H-0FFFFH, upper nibble zero
// - pair jump joins code bank with pair; call any pair, branch accumulator pair only
// - implied operand exists only for unsigned multiply, selecting X
// - 3-bit field picks X,A,C,B,E,D,L,H; 2-bit field picks one of four pairs
// - direct operand uses 16-bit immediate in F0000H-FFFFFH without prefix
// - bank prefix supplies upper four address bits from upper bank register
// - short direct address from 8-bit field, always FFE20H-FFF1FH
// - word short direct operands must be even; odd field flagged
// - special-register address from 8-bit field, always FFF00H-FFFFFH
// - word special-register access must be even; odd field flagged
// - register indirect uses pair three or four, F region or prefixed bank
// - based adds 8 or 16-bit offset to pair, stack pointer, B, C or pair two
// - based indexed adds B or C to pair four, optional prefix
// - stack operations address memory through the stack pointer
// - stack addresses outside internal RAM are refused
`ifndef CAGEN_REGS_SVH
`define CAGEN_REGS_SVH

`define CAGEN_DATA_HI     4'hF
`define CAGEN_ZERO_HI     4'h0
`define CAGEN_TBL_BASE    16'h0080
`define CAGEN_SHORT_PAGE  12'hFFE
`define CAGEN_SFR_PAGE    12'hFFF
`define CAGEN_SHORT_SPLIT 8'h20
`define CAGEN_ADDR_RST    20'h00000
`define CAGEN_RAM_LO      20'hF8000
`define CAGEN_RAM_HI      20'hFFEFF

`endif

// File: cagen_pkg.sv
package cagen_pkg;

    // operation selected by the decoder
    typedef enum logic [3:0] {
        OP_BR_REL8   = 4'h0,
        OP_BR_REL16  = 4'h1,
        OP_JMP_IMM20 = 4'h2,
        OP_JMP_IMM16 = 4'h3,
        OP_TBL_CALL  = 4'h4,
        OP_JMP_PAIR  = 4'h5,
        OP_UMUL_IMPL = 4'h6,
        OP_REG8      = 4'h7,
        OP_REG16     = 4'h8,
        OP_DIRECT    = 4'h9,
        OP_SHORT     = 4'hA,
        OP_SFR       = 4'hB,
        OP_REG_IND   = 4'hC,
        OP_BASED     = 4'hD,
        OP_BASED_IDX = 4'hE,
        OP_STACK     = 4'hF
    } cagen_op_t;

    // base register of based modes
    typedef enum logic [2:0] {
        BASE_P4  = 3'b000,
        BASE_P3  = 3'b001,
        BASE_STK = 3'b010,
        BASE_B   = 3'b011,
        BASE_C   = 3'b100,
        BASE_P2  = 3'b101
    } cagen_base_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_TBL  = 1'b1
    } cagen_state_t;

    typedef struct packed {
        logic        valid;
        cagen_op_t   op;
        logic        is_call;
        logic        bank_pfx;
        logic        word;
        logic        off_byte;
        logic [2:0]  reg_sel;
        logic [1:0]  pair_sel;
        cagen_base_t base_sel;
        logic [4:0]  tbl_idx;
        logic [7:0]  field8;
        logic [15:0] imm16;
        logic [19:0] imm20;
    } cagen_req_t;

    typedef struct packed {
        logic [19:0] next_instr_addr;
        logic [15:0] accum_pair;
        logic [15:0] pair_two;
        logic [15:0] pair_three;
        logic [15:0] pair_four;
        logic [15:0] stack_pointer;
        logic [3:0]  code_bank;
        logic [3:0]  upper_bank_register;
    } cagen_ctx_t;

    typedef struct packed {
        logic        prog_load;
        logic [19:0] prog_target;
        logic        dat_valid;
        logic [19:0] dat_addr;
        logic        dat_word;
        logic        stack_acc;
        logic        align_err;
        logic        bad_op;
        logic [7:0]  reg8;
        logic [15:0] reg16;
    } cagen_out_t;

endpackage

// File: cagen_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "cagen_regs.svh"

module cagen_core
    import cagen_pkg::*;
#(
    parameter logic [19:0] RAM_LO = `CAGEN_RAM_LO,
    parameter logic [19:0] RAM_HI = `CAGEN_RAM_HI
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    // decoder side
    input  wire cagen_req_t  req,
    input  wire cagen_ctx_t  ctx,
    output logic             req_ready,
    // table word read
    output logic             tbl_rd_req,
    output logic [19:0]      tbl_rd_addr,
    input  wire logic        tbl_rd_valid,
    input  wire logic [15:0] tbl_rd_data,
    // results
    output cagen_out_t       res
);

    //------------------------------------------------------------
    // state
    //------------------------------------------------------------
    cagen_state_t state_q, state_d;
    cagen_out_t   out_q, out_d;
    logic         trd_q, trd_d;
    logic [19:0]  tad_q, tad_d;

    logic         take;
    logic [7:0]   byte_sel;
    logic [15:0]  pair_sel_val;
    logic [15:0]  base_val;
    logic [15:0]  off_val;
    logic [3:0]   data_hi;
    logic [19:0]  stk_addr;

    assign req_ready   = (state_q == ST_IDLE);
    assign take        = clk_en && req.valid && req_ready;
    assign tbl_rd_req  = trd_q;
    assign tbl_rd_addr = tad_q;
    assign res         = out_q;

    // register operand select: pair from top bits, byte from bit 0
    always_comb begin
        case (req.pair_sel)
            2'b00:   pair_sel_val = ctx.accum_pair;
            2'b01:   pair_sel_val = ctx.pair_two;
            2'b10:   pair_sel_val = ctx.pair_three;
            default: pair_sel_val = ctx.pair_four;
        endcase
        case (req.reg_sel)
            3'd0:    byte_sel = ctx.accum_pair[7:0];   // X
            3'd1:    byte_sel = ctx.accum_pair[15:8];  // A
            3'd2:    byte_sel = ctx.pair_two[7:0];     // C
            3'd3:    byte_sel = ctx.pair_two[15:8];    // B
            3'd4:    byte_sel = ctx.pair_three[7:0];   // E
            3'd5:    byte_sel = ctx.pair_three[15:8];  // D
            3'd6:    byte_sel = ctx.pair_four[7:0];    // L
            default: byte_sel = ctx.pair_four[15:8];   // H
        endcase
    end

    // base and offset of based modes, prefix nibble
    always_comb begin
        case (req.base_sel)
            BASE_P4:  base_val = ctx.pair_four;
            BASE_P3:  base_val = ctx.pair_three;
            BASE_STK: base_val = ctx.stack_pointer;
            BASE_B:   base_val = {8'h00, ctx.pair_two[15:8]};
            BASE_C:   base_val = {8'h00, ctx.pair_two[7:0]};
            default:  base_val = ctx.pair_two;
        endcase
        off_val  = req.off_byte ? {8'h00, req.imm16[7:0]} : req.imm16;
        data_hi  = req.bank_pfx ? ctx.upper_bank_register : `CAGEN_DATA_HI;
        stk_addr = {`CAGEN_DATA_HI, ctx.stack_pointer};
    end

    //------------------------------------------------------------
    // next state and results
    //------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        trd_d   = 1'b0;
        tad_d   = tad_q;
        out_d   = out_q;
        out_d.prog_load = 1'b0;
        out_d.dat_valid = 1'b0;
        out_d.align_err = 1'b0;
        out_d.bad_op    = 1'b0;
        out_d.stack_acc = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (req.valid) begin
                    out_d.dat_word = req.word;
                    case (req.op)
                        OP_BR_REL8: begin
                            out_d.prog_load   = 1'b1;
                            out_d.prog_target = ctx.next_instr_addr + {{12{req.imm16[7]}}, req.imm16[7:0]};
                        end
                        OP_BR_REL16: begin
                            out_d.prog_load   = 1'b1;
                            out_d.prog_target = ctx.next_instr_addr + {{4{req.imm16[15]}}, req.imm16};
                        end
                        OP_JMP_IMM20: begin
                            out_d.prog_load   = 1'b1;
                            out_d.prog_target = req.imm20;
                        end
                        OP_JMP_IMM16: begin
                            out_d.prog_load   = 1'b1;
                            out_d.prog_target = {`CAGEN_ZERO_HI, req.imm16};
                        end
                        OP_TBL_CALL: begin
                            trd_d   = 1'b1;
                            tad_d   = {`CAGEN_ZERO_HI, `CAGEN_TBL_BASE + {10'h000, req.tbl_idx, 1'b0}};
                            state_d = ST_TBL;
                        end
                        OP_JMP_PAIR: begin
                            // branch form exists only for the accumulator pair
                            if (req.is_call || req.pair_sel == 2'b00) begin
                                out_d.prog_load   = 1'b1;
                                out_d.prog_target = {ctx.code_bank, pair_sel_val};
                            end else begin
                                out_d.bad_op = 1'b1;
                            end
                        end
                        OP_UMUL_IMPL: begin
                            out_d.reg8 = ctx.accum_pair[7:0];
                        end
                        OP_REG8: begin
                            out_d.reg8 = byte_sel;
                        end
                        OP_REG16: begin
                            out_d.reg16 = pair_sel_val;
                        end
                        OP_DIRECT: begin
                            out_d.dat_valid = 1'b1;
                            out_d.dat_addr  = {data_hi, req.imm16};
                        end
                        OP_SHORT: begin
                            out_d.dat_valid = 1'b1;
                            if (req.field8 >= `CAGEN_SHORT_SPLIT) begin
                                out_d.dat_addr = {`CAGEN_SHORT_PAGE, req.field8};
                            end else begin
                                out_d.dat_addr = {`CAGEN_SFR_PAGE, req.field8};
                            end
                            if (req.word && req.field8[0]) begin
                                out_d.align_err   = 1'b1;
                                out_d.dat_addr[0] = 1'b0;
                            end
                        end
                        OP_SFR: begin
                            out_d.dat_valid = 1'b1;
                            out_d.dat_addr  = {`CAGEN_SFR_PAGE, req.field8};
                            if (req.word && req.field8[0]) begin
                                out_d.align_err   = 1'b1;
                                out_d.dat_addr[0] = 1'b0;
                            end
                        end
                        OP_REG_IND: begin
                            out_d.dat_valid = 1'b1;
                            out_d.dat_addr  = {data_hi, req.pair_sel[0] ? ctx.pair_four : ctx.pair_three};
                        end
                        OP_BASED: begin
                            out_d.dat_valid = 1'b1;
                            out_d.dat_addr  = {data_hi, base_val + off_val};
                        end
                        OP_BASED_IDX: begin
                            out_d.dat_valid = 1'b1;
                            out_d.dat_addr  = {data_hi, ctx.pair_four + base_val};
                        end
                        default: begin
                            // stack outside the internal RAM window is refused
                            if (stk_addr >= RAM_LO && stk_addr <= RAM_HI) begin
                                out_d.dat_valid = 1'b1;
                                out_d.stack_acc = 1'b1;
                                out_d.dat_addr  = stk_addr;
                            end else begin
                                out_d.bad_op = 1'b1;
                            end
                        end
                    endcase
                end
            end
            default: begin
                // wait for the table word, upper nibble forced to zero
                if (tbl_rd_valid) begin
                    out_d.prog_load   = 1'b1;
                    out_d.prog_target = {`CAGEN_ZERO_HI, tbl_rd_data};
                    state_d           = ST_IDLE;
                end
            end
        endcase
    end

    // register stage, frozen while clk_en is low
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE;
            trd_q   <= 1'b0;
            tad_q   <= `CAGEN_ADDR_RST;
            out_q   <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            trd_q   <= trd_d;
            tad_q   <= tad_d;
            out_q   <= out_d;
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_tbl_issue;
        take && req.op == OP_TBL_CALL;
    endsequence

    sequence s_tbl_answer;
        state_q == ST_TBL && clk_en && tbl_rd_valid;
    endsequence

    // table read strobe is one enabled cycle wide
    sequence s_tbl_pulse;
        tbl_rd_req ##1 !tbl_rd_req;
    endsequence

    a_rel8_target: assert property (take && req.op == OP_BR_REL8 |=> res.prog_load &&
        res.prog_target == $past(ctx.next_instr_addr) + {{12{$past(req.imm16[7])}}, $past(req.imm16[7:0])})
        else $error("relative target wrong");
    a_rel_only_branch: assert property (take && req.op >= OP_UMUL_IMPL |=> !res.prog_load)
        else $error("data op loaded program counter");
    a_imm16_zero_hi: assert property (take && req.op == OP_JMP_IMM16 |=> res.prog_target[19:16] == 4'h0)
        else $error("imm16 upper nibble not zero");
    a_tbl_addr_range: assert property (s_tbl_issue |=> tbl_rd_req && tbl_rd_addr >= 20'h00080
        && tbl_rd_addr <= 20'h000BF && !tbl_rd_addr[0])
        else $error("table address out of range");
    a_tbl_target_low: assert property (state_q == ST_TBL && clk_en && tbl_rd_valid |=>
        res.prog_load && res.prog_target[19:16] == 4'h0 && state_q == ST_IDLE)
        else $error("table target not in low 64 KB");
    a_pair_acc_only: assert property (take && req.op == OP_JMP_PAIR && !req.is_call
        && req.pair_sel != 2'b00 |=> res.bad_op && !res.prog_load)
        else $error("branch via non-accumulator pair accepted");
    a_short_window: assert property (res.dat_valid && $past(req.op) == OP_SHORT && $past(take) |->
        res.dat_addr >= 20'hFFE20 && res.dat_addr <= 20'hFFF1F)
        else $error("short direct address out of window");
    a_sfr_window: assert property (take && req.op == OP_SFR |=>
        res.dat_addr == {12'hFFF, $past(req.field8)} || res.align_err)
        else $error("special register address wrong");
    a_word_even: assert property (take && req.word && req.field8[0]
        && (req.op == OP_SHORT || req.op == OP_SFR)
        |=> res.align_err && !res.dat_addr[0])
        else $error("odd word address not flagged");
    a_direct_region: assert property (take && req.op == OP_DIRECT && !req.bank_pfx |=>
        res.dat_addr == {4'hF, $past(req.imm16)})
        else $error("direct address not in F region");
    a_stack_in_ram: assert property (res.stack_acc |-> res.dat_addr >= RAM_LO && res.dat_addr <= RAM_HI)
        else $error("stack access outside internal RAM");

    // table call: single strobe, decoder held off, word loaded with zero upper nibble
    a_tbl_read_pulse: assert property (s_tbl_issue ##1 clk_en |-> s_tbl_pulse)
        else $error("table read strobe not a single pulse");
    a_tbl_hold_off: assert property (s_tbl_issue |=> !req_ready && !res.prog_load)
        else $error("decoder not held off during table call");
    a_tbl_word_load: assert property (s_tbl_answer |=> res.prog_target == {4'h0, $past(tbl_rd_data)})
        else $error("table target not the table word");

    // program counter targets
    a_rel16_target: assert property (take && req.op == OP_BR_REL16 |=> res.prog_load &&
        res.prog_target == $past(ctx.next_instr_addr) + {{4{$past(req.imm16[15])}}, $past(req.imm16)})
        else $error("16-bit relative target wrong");
    a_imm20_target: assert property (take && req.op == OP_JMP_IMM20 |=>
        res.prog_load && res.prog_target == $past(req.imm20))
        else $error("20-bit immediate target wrong");
    a_pair_code_bank: assert property (take && req.op == OP_JMP_PAIR && req.is_call |=>
        res.prog_load && res.prog_target[19:16] == $past(ctx.code_bank))
        else $error("pair target lacks code bank");

    // data operand addresses
    a_umul_x_only: assert property (take && req.op == OP_UMUL_IMPL |=>
        res.reg8 == $past(ctx.accum_pair[7:0]) && !res.dat_valid)
        else $error("implied operand is not X");
    a_direct_bank: assert property (take && req.op == OP_DIRECT && req.bank_pfx |=>
        res.dat_addr == {$past(ctx.upper_bank_register), $past(req.imm16)})
        else $error("bank prefix not used for upper bits");
    a_short_low_page: assert property (take && req.op == OP_SHORT && req.field8 < 8'h20 |=>
        res.dat_addr[19:8] == 12'hFFF)
        else $error("short field below 20H not in upper page");
    a_reg_ind_region: assert property (take && req.op == OP_REG_IND && !req.bank_pfx |=>
        res.dat_valid && res.dat_addr[19:16] == 4'hF)
        else $error("register indirect outside F region");
    a_idx_sum_wrap: assert property (take && req.op == OP_BASED_IDX && req.base_sel == BASE_C |=>
        res.dat_addr[15:0] == 16'($past(ctx.pair_four) + {8'h00, $past(ctx.pair_two[7:0])}))
        else $error("based indexed sum wrong");
    a_stack_refused: assert property (take && req.op == OP_STACK &&
        {4'hF, ctx.stack_pointer} < RAM_LO |=> res.bad_op && !res.dat_valid)
        else $error("stack access below internal RAM accepted");

endmodule // cagen_core

`default_nettype wire

// File: cagen_tbl_mem.sv
`timescale 1ns/1ps
`default_nettype none

module cagen_tbl_mem (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    // answer delay in cycles after the read pulse
    input  wire logic [3:0]  lat,
    // table word read port
    input  wire logic        tbl_rd_req,
    input  wire logic [19:0] tbl_rd_addr,
    output logic             tbl_rd_valid,
    output logic [15:0]      tbl_rd_data
);
    logic       busy_q;
    logic [3:0] wait_q;

    // one read at a time; data toggles outside the valid cycle so stale words never match
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_q       <= 1'b0;
            wait_q       <= 4'h0;
            tbl_rd_valid <= 1'b0;
            tbl_rd_data  <= 16'h0000;
        end else begin
            tbl_rd_valid <= 1'b0;
            tbl_rd_data  <= ~tbl_rd_data;
            if (tbl_rd_req) begin
                busy_q <= 1'b1;
                wait_q <= lat;
            end else if (busy_q && wait_q != 4'h0) begin
                wait_q <= wait_q - 4'h1;
            end else if (busy_q) begin
                busy_q       <= 1'b0;
                tbl_rd_valid <= 1'b1;
                tbl_rd_data  <= {~tbl_rd_addr[7:0], tbl_rd_addr[7:0]};
            end
        end
    end
endmodule // cagen_tbl_mem

`default_nettype wire

// File: test_cpu_address_generation.sv
`timescale 1ns/1ps
`default_nettype none

module test_cpu_address_generation import cagen_pkg::*;;
    logic        clk_sys;
    logic        arst_n;
    logic        clk_en;
    logic [3:0]  lat;
    cagen_req_t  req;
    cagen_ctx_t  ctx;
    cagen_out_t  res;
    logic        req_ready;
    logic        tbl_rd_req;
    logic [19:0] tbl_rd_addr;
    logic        tbl_rd_valid;
    logic [15:0] tbl_rd_data;
    int          mismatches;
    int          samples_checked;

    cagen_core dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .req(req), .ctx(ctx),
        .req_ready(req_ready), .tbl_rd_req(tbl_rd_req), .tbl_rd_addr(tbl_rd_addr),
        .tbl_rd_valid(tbl_rd_valid), .tbl_rd_data(tbl_rd_data), .res(res));
    cagen_tbl_mem mem_u (.clk_sys(clk_sys), .arst_n(arst_n), .lat(lat), .tbl_rd_req(tbl_rd_req),
        .tbl_rd_addr(tbl_rd_addr), .tbl_rd_valid(tbl_rd_valid), .tbl_rd_data(tbl_rd_data));

    // 40 MHz clock
    always #12.5 clk_sys = ~clk_sys;

    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // one-cycle request, returns in the cycle where results show
    task automatic go(input cagen_op_t op);
        @(posedge clk_sys); #1;
        req.valid = 1'b1;
        req.op    = op;
        @(posedge clk_sys); #1;
        req.valid = 1'b0;
    endtask

    task automatic jump(input cagen_op_t op, input logic [19:0] exp);
        go(op);
        chk(res.prog_load, 1'b1);
        chk(res.prog_target, exp);
    endtask

    task automatic dat(input cagen_op_t op, input logic [19:0] exp);
        go(op);
        chk(res.dat_valid, 1'b1);
        chk(res.dat_addr, exp);
    endtask

    task automatic t_branch;
        ctx.next_instr_addr = 20'h12000;
        req.field8 = 8'h80;
        req.imm16  = 16'hFF80;
        jump(OP_BR_REL8, 20'h11F80);
        req.field8 = 8'h7F;
        req.imm16  = 16'h007F;
        jump(OP_BR_REL8, 20'h1207F);
        req.imm16  = 16'h8000;
        jump(OP_BR_REL16, 20'h0A000);
        req.imm16  = 16'h7FFF;
        jump(OP_BR_REL16, 20'h19FFF);
        go(OP_DIRECT);
        chk(res.prog_load, 1'b0);
        req.imm20 = 20'hABCDE;
        jump(OP_JMP_IMM20, 20'hABCDE);
        req.imm16 = 16'h1234;
        jump(OP_JMP_IMM16, 20'h01234);
    endtask

    // table call with a slow and a prompt table read, refusing a request meanwhile
    task automatic t_tbl(input logic [4:0] idx, input logic [3:0] l, input logic [7:0] a);
        lat = l;
        req.tbl_idx = idx;
        go(OP_TBL_CALL);
        chk(tbl_rd_req, 1'b1);
        chk(tbl_rd_addr, {12'h000, a});
        chk(req_ready, 1'b0);
        req.valid = 1'b1;
        req.op    = OP_DIRECT;
        for (int i = 0; i < 20 && res.prog_load !== 1'b1; i++) begin
            @(posedge clk_sys); #1;
        end
        req.valid = 1'b0;
        chk(res.prog_load, 1'b1);
        chk(res.dat_valid, 1'b0);
        chk(res.prog_target, {4'h0, ~a, a});
        chk(req_ready, 1'b1);
    endtask

    task automatic t_pair;
        ctx.code_bank  = 4'h7;
        ctx.accum_pair = 16'hAAAA;
        ctx.pair_two   = 16'h2B2C;
        ctx.pair_three = 16'h3D3E;
        ctx.pair_four  = 16'h4444;
        req.is_call  = 1'b1;
        req.pair_sel = 2'h3;
        jump(OP_JMP_PAIR, 20'h74444);
        req.is_call  = 1'b0;
        req.pair_sel = 2'h0;
        jump(OP_JMP_PAIR, 20'h7AAAA);
        req.pair_sel = 2'h1;
        go(OP_JMP_PAIR);
        chk(res.bad_op, 1'b1);
        chk(res.prog_load, 1'b0);
    endtask

    task automatic t_regs;
        logic [15:0] p [4];
        p = '{ctx.accum_pair, ctx.pair_two, ctx.pair_three, ctx.pair_four};
        for (int i = 0; i < 8; i++) begin
            req.reg_sel = 3'(i);
            go(OP_REG8);
            chk(res.reg8, i[0] ? p[i/2][15:8] : p[i/2][7:0]);
        end
        for (int j = 0; j < 4; j++) begin
            req.pair_sel = 2'(j);
            go(OP_REG16);
            chk(res.reg16, p[j]);
        end
        req.reg_sel = 3'h3;
        go(OP_UMUL_IMPL);
        chk(res.reg8, 8'hAA);
        chk(res.prog_load, 1'b0);
    endtask

    task automatic fld(input cagen_op_t op, input logic [7:0] f, input logic w,
                       input logic [19:0] exp, input logic err);
        req.field8 = f;
        req.word   = w;
        dat(op, exp);
        chk(res.align_err, err);
        chk(res.dat_word, w);
    endtask

    task automatic t_data;
        ctx.upper_bank_register = 4'h3;
        req.bank_pfx = 1'b0;
        req.imm16    = 16'h1234;
        dat(OP_DIRECT, 20'hF1234);
        req.bank_pfx = 1'b1;
        dat(OP_DIRECT, 20'h31234);
        req.bank_pfx = 1'b0;
        fld(OP_SHORT, 8'h20, 1'b0, 20'hFFE20, 1'b0);
        fld(OP_SHORT, 8'hFF, 1'b0, 20'hFFEFF, 1'b0);
        fld(OP_SHORT, 8'h1F, 1'b0, 20'hFFF1F, 1'b0);
        fld(OP_SHORT, 8'h21, 1'b1, 20'hFFE20, 1'b1);
        fld(OP_SFR, 8'h00, 1'b0, 20'hFFF00, 1'b0);
        fld(OP_SFR, 8'hFF, 1'b1, 20'hFFFFE, 1'b1);
        req.word     = 1'b0;
        req.pair_sel = 2'h1;
        dat(OP_REG_IND, 20'hF4444);
        req.pair_sel = 2'h0;
        req.bank_pfx = 1'b1;
        dat(OP_REG_IND, 20'h33D3E);
        req.base_sel = BASE_C;
        dat(OP_BASED_IDX, 20'h34470);
        req.bank_pfx = 1'b0;
        req.base_sel = BASE_B;
        dat(OP_BASED_IDX, 20'hF446F);
    endtask

    task automatic bas(input cagen_base_t b, input logic [15:0] off, input logic [19:0] exp);
        req.base_sel = b;
        req.off_byte = (off[15:8] == 8'h00);
        req.field8   = off[7:0];
        req.imm16    = off;
        dat(OP_BASED, exp);
    endtask

    task automatic t_based;
        ctx.stack_pointer = 16'hFFF8;
        bas(BASE_P4, 16'hF000, 20'hF3444);
        bas(BASE_P3, 16'h0102, 20'hF3E40);
        bas(BASE_STK, 16'h00F0, 20'hF00E8);
        bas(BASE_B, 16'h0100, 20'hF012B);
        bas(BASE_C, 16'h0000, 20'hF002C);
        bas(BASE_P2, 16'h0101, 20'hF2C2D);
        ctx.stack_pointer = 16'hFE00;
        dat(OP_STACK, 20'hFFE00);
        chk(res.stack_acc, 1'b1);
        ctx.stack_pointer = 16'h1000;
        go(OP_STACK);
        chk(res.bad_op, 1'b1);
        chk(res.dat_valid, 1'b0);
    endtask

    // enable low holds a request off, then a mid-run reset clears the results
    task automatic t_hold;
        req.imm16 = 16'h5A5A;
        @(posedge clk_sys); #1;
        clk_en    = 1'b0;
        req.valid = 1'b1;
        req.op    = OP_DIRECT;
        repeat (2) @(posedge clk_sys);
        #1 chk(res.dat_addr, 20'hFFE00);
        clk_en = 1'b1;
        @(posedge clk_sys); #1;
        req.valid = 1'b0;
        chk(res.dat_addr, 20'hF5A5A);
        arst_n = 1'b0;
        @(posedge clk_sys); #1;
        chk(res.dat_addr, 20'h00000);
        chk(req_ready, 1'b1);
        arst_n = 1'b1;
        dat(OP_DIRECT, 20'hF5A5A);
    endtask

    initial begin
        clk_sys = 1'b0;
        arst_n  = 1'b0;
        clk_en  = 1'b1;
        lat     = 4'h0;
        req     = '0;
        ctx     = '0;
        mismatches      = 0;
        samples_checked = 0;
        repeat (3) @(posedge clk_sys);
        #1 arst_n = 1'b1;
        t_branch;
        t_tbl(5'h1F, 4'h3, 8'hBE);
        t_tbl(5'h00, 4'h0, 8'h80);
        t_pair;
        t_regs;
        t_data;
        t_based;
        t_hold;
        final_report;
    end

    // hang guard at 4000 cycles, far beyond the hundred or so cycles the tests need
    initial begin
        #100us;
        mismatches++;
        final_report;
    end
endmodule // test_cpu_address_generation

`default_nettype wire
